// [rtl/bgp_gpio.sv]
// Banked general-purpose pin block with APB registers, edge interrupts and DMA events.
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RULE_01: An output pin drives the stored output register bit.
// RULE_02: An input pin's sampled level is readable in the input register.
// RULE_03: Pins form banks of sixteen; bank 0 holds pins 0 to 15.
// RULE_04: 104 pins, indices 103 down to 0, seven banks, last partly filled.
// RULE_05: Pins 9 to 0 each have their own interrupt output.
// RULE_06: Each of seven banks has one aggregated interrupt output.
// RULE_07: Per pin, rising, falling or both edges select event generation.
// RULE_08: Pins 9 to 0 each have their own DMA event output.
// RULE_09: Each bank has one aggregated DMA event output.
// RULE_10: Set and clear registers change only bits written as one.
// RULE_11: Input and output registers are separate; output writable directly.
// RULE_12: Reading the output register returns driven levels, not pin levels.
// RULE_13: Input register shows real pin level even for output pins.
// RULE_14: Each pin input passes a two-stage synchroniser first.
module bgp_gpio
    import bgp_pkg::*;
(
    input  wire logic                  clk_in,
    input  wire logic                  rst_in,
    input  wire logic                  psel_in,
    input  wire logic                  penable_in,
    input  wire logic                  pwrite_in,
    input  wire logic [11:0]           paddr_in,
    input  wire logic [31:0]           pwdata_in,
    output var  logic [31:0]           prdata_out,
    output var  logic                  pready_out,
    output var  logic                  pslverr_out,
    input  wire logic [NUM_PINS-1:0]   pin_in,
    output var  logic [NUM_PINS-1:0]   pin_out,
    output var  logic [NUM_PINS-1:0]   pin_oe_n_out,
    output var  logic [NUM_UNIQUE-1:0] pin_irq_out,
    output var  logic [NUM_BANKS-1:0]  bank_irq_out,
    output var  logic [NUM_UNIQUE-1:0] pin_dma_controller_event_out,
    output var  logic [NUM_BANKS-1:0]  bank_dma_controller_event_out,
    output var  logic                  irq_out
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Picks the sixteen bits of one bank out of a flat pin vector.
    function automatic logic [BANK_W-1:0] bank_slice(input logic [FLAT_W-1:0] v,
                                                     input logic [2:0]        b);
        bank_slice = v[b*BANK_W +: BANK_W];
    endfunction : bank_slice

    // Spreads a per-bank strobe over that bank's sixteen lanes.
    function automatic logic [FLAT_W-1:0] bank_lanes(input logic       en,
                                                     input logic [2:0] b);
        logic [FLAT_W-1:0] ones;
        ones = {{(FLAT_W-BANK_W){1'b0}}, {BANK_W{1'b1}}};
        bank_lanes = en ? (ones << (b * BANK_W)) : ZERO_RST;
    endfunction : bank_lanes

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [FLAT_W-1:0] dir_q;
    logic [FLAT_W-1:0] dir_d;
    logic [FLAT_W-1:0] out_q;
    logic [FLAT_W-1:0] out_d;
    logic [FLAT_W-1:0] rise_en_q;
    logic [FLAT_W-1:0] rise_en_d;
    logic [FLAT_W-1:0] fall_en_q;
    logic [FLAT_W-1:0] fall_en_d;
    logic [FLAT_W-1:0] stat_q;
    logic [FLAT_W-1:0] stat_d;
    logic [FLAT_W-1:0] mask_q;
    logic [FLAT_W-1:0] mask_d;
    logic [NUM_PINS-1:0] sync1_q;
    logic [NUM_PINS-1:0] sync2_q;
    logic [NUM_PINS-1:0] sync3_q;
    logic [31:0]       rdata_d;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------

    // The slave inserts one wait state so read data comes from a flop.
    wire logic [2:0]  acc_bank  = paddr_in[8:6];
    wire logic [3:0]  acc_idx   = paddr_in[5:2];
    wire logic        in_range  = (acc_bank < 3'(NUM_BANKS)) && (acc_idx <= IDX_MASK)
                                  && (paddr_in[11:9] == 3'h0) && (paddr_in[1:0] == 2'h0);
    wire logic        acc_first = psel_in && penable_in && !pready_out;
    wire logic        acc_done  = psel_in && penable_in && pready_out;
    wire logic        wr_ok     = acc_done && pwrite_in && in_range;
    wire logic [FLAT_W-1:0] wdat = {NUM_BANKS{pwdata_in[BANK_W-1:0]}};

    // Lane strobes for each writable register.
    wire logic [FLAT_W-1:0] w_dir  = bank_lanes(wr_ok && acc_idx == IDX_DIR,  acc_bank);
    wire logic [FLAT_W-1:0] w_out  = bank_lanes(wr_ok && acc_idx == IDX_OUT,  acc_bank);
    wire logic [FLAT_W-1:0] w_set  = bank_lanes(wr_ok && acc_idx == IDX_SET,  acc_bank);
    wire logic [FLAT_W-1:0] w_clr  = bank_lanes(wr_ok && acc_idx == IDX_CLR,  acc_bank);
    wire logic [FLAT_W-1:0] w_rise = bank_lanes(wr_ok && acc_idx == IDX_RISE, acc_bank);
    wire logic [FLAT_W-1:0] w_fall = bank_lanes(wr_ok && acc_idx == IDX_FALL, acc_bank);
    wire logic [FLAT_W-1:0] w_stat = bank_lanes(wr_ok && acc_idx == IDX_STAT, acc_bank);
    wire logic [FLAT_W-1:0] w_mask = bank_lanes(wr_ok && acc_idx == IDX_MASK, acc_bank);

    // ------------------------------------------------------------------
    // Pin sampling and edge detection
    // ------------------------------------------------------------------

    // Sampled level kept in the flat layout, empty lanes read as zero.
    wire logic [FLAT_W-1:0] in_view = {{(FLAT_W-NUM_PINS){1'b0}}, sync2_q}; // RULE_13
    wire logic [FLAT_W-1:0] prev    = {{(FLAT_W-NUM_PINS){1'b0}}, sync3_q};

    // Edge events honour each pin's rising and falling selections.
    wire logic [FLAT_W-1:0] ev = ((in_view & ~prev & rise_en_q)
                                 | (~in_view & prev & fall_en_q)) & POP_MASK; // RULE_07

    // One aggregate per bank of sixteen pins.
    logic [NUM_BANKS-1:0] bank_ev;
    always_comb begin
        for (int b = 0; b < NUM_BANKS; b++) begin
            bank_ev[b] = |ev[b*BANK_W +: BANK_W]; // RULE_03
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic for the register file
    // ------------------------------------------------------------------

    // Only implemented pins hold state; the rest stay zero.
    assign dir_d     = ((dir_q & ~w_dir) | (wdat & w_dir)) & POP_MASK; // RULE_04
    assign out_d     = (((out_q & ~w_out) | (wdat & w_out)) // RULE_11
                       | (wdat & w_set)) & ~(wdat & w_clr) & POP_MASK; // RULE_10
    assign rise_en_d = ((rise_en_q & ~w_rise) | (wdat & w_rise)) & POP_MASK;
    assign fall_en_d = ((fall_en_q & ~w_fall) | (wdat & w_fall)) & POP_MASK;
    assign mask_d    = ((mask_q & ~w_mask) | (wdat & w_mask)) & POP_MASK;

    // A fresh event wins over a write-one clear in the same cycle.
    assign stat_d    = (stat_q & ~(wdat & w_stat)) | ev;

    // Read mux; set and clear registers read as zero, unmapped reads as zero.
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (in_range) begin
            case (acc_idx)
                IDX_DIR:  rdata_d[BANK_W-1:0] = bank_slice(dir_q, acc_bank);
                IDX_OUT:  rdata_d[BANK_W-1:0] = bank_slice(out_q, acc_bank); // RULE_12
                IDX_IN:   rdata_d[BANK_W-1:0] = bank_slice(in_view, acc_bank); // RULE_02
                IDX_RISE: rdata_d[BANK_W-1:0] = bank_slice(rise_en_q, acc_bank);
                IDX_FALL: rdata_d[BANK_W-1:0] = bank_slice(fall_en_q, acc_bank);
                IDX_STAT: rdata_d[BANK_W-1:0] = bank_slice(stat_q, acc_bank);
                IDX_MASK: rdata_d[BANK_W-1:0] = bank_slice(mask_q, acc_bank);
                default:  rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------------

    // The first stage feeds only the second; sync3 is the edge history.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= pin_in; // RULE_14
            sync2_q <= sync1_q; // RULE_14
            sync3_q <= sync2_q;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------

    // All pins come up as inputs so nothing is driven before software decides.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            dir_q     <= DIR_RST & POP_MASK;
            out_q     <= ZERO_RST;
            rise_en_q <= ZERO_RST;
            fall_en_q <= ZERO_RST;
            stat_q    <= ZERO_RST;
            mask_q    <= ZERO_RST;
        end else begin
            dir_q     <= dir_d;
            out_q     <= out_d;
            rise_en_q <= rise_en_d;
            fall_en_q <= fall_en_d;
            stat_q    <= stat_d;
            mask_q    <= mask_d;
        end
    end

    // APB response: ready rises for one cycle after the first access cycle.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end else begin
            pready_out  <= acc_first;
            pslverr_out <= acc_first && !in_range;
            prdata_out  <= (acc_first && !pwrite_in) ? rdata_d : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Pin drive and event outputs
    // ------------------------------------------------------------------

    // Event outputs are one-cycle pulses; the level irq uses sticky status.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pin_out                       <= '0;
            pin_oe_n_out                  <= '1;
            pin_irq_out                   <= '0;
            bank_irq_out                  <= '0;
            pin_dma_controller_event_out  <= '0;
            bank_dma_controller_event_out <= '0;
            irq_out                       <= 1'b0;
        end else begin
            pin_out                       <= out_d[NUM_PINS-1:0]; // RULE_01
            pin_oe_n_out                  <= dir_d[NUM_PINS-1:0]; // RULE_01
            pin_irq_out                   <= ev[NUM_UNIQUE-1:0]; // RULE_05
            bank_irq_out                  <= bank_ev; // RULE_06
            pin_dma_controller_event_out  <= ev[NUM_UNIQUE-1:0]; // RULE_08
            bank_dma_controller_event_out <= bank_ev; // RULE_09
            irq_out                       <= |(stat_d & mask_d);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    wire logic acc0 = acc_done && acc_bank == 3'h0 && in_range;

    sequence s_out_write0;
        acc0 && pwrite_in && acc_idx == IDX_OUT;
    endsequence

    sequence s_set_write0;
        acc0 && pwrite_in && acc_idx == IDX_SET;
    endsequence

    sequence s_clr_write0;
        acc0 && pwrite_in && acc_idx == IDX_CLR;
    endsequence

    sequence s_dir_write1;
        acc_done && in_range && pwrite_in && acc_bank == 3'h1 && acc_idx == IDX_DIR;
    endsequence

    property p_out_drive;
        @(posedge clk_in) disable iff (rst_in)
        s_out_write0 |=> pin_out[15:0] == $past(pwdata_in[15:0]);
    endproperty
    a_out_drive: assert property (p_out_drive) else $error("pin drive misses write"); // RULE_01

    property p_in_sample;
        @(posedge clk_in) disable iff (rst_in)
        ##3 in_view[NUM_PINS-1:0] == $past(pin_in, 2);
    endproperty
    a_in_sample: assert property (p_in_sample) else $error("input not two stages late"); // RULE_14

    property p_in_read;
        @(posedge clk_in) disable iff (rst_in)
        (acc_first && !pwrite_in && acc_bank == 3'h1 && acc_idx == IDX_IN && in_range)
        |=> prdata_out[15:0] == $past(sync2_q[31:16]);
    endproperty
    a_in_read: assert property (p_in_read) else $error("input read wrong bank"); // RULE_02

    property p_last_bank;
        @(posedge clk_in) disable iff (rst_in)
        (acc_first && !pwrite_in && acc_bank == 3'h6) |=> prdata_out[31:8] == 24'h000000;
    endproperty
    a_last_bank: assert property (p_last_bank) else $error("empty pins read nonzero"); // RULE_04

    property p_pin_rise;
        @(posedge clk_in) disable iff (rst_in)
        ($rose(sync2_q[3]) && rise_en_q[3]) |=> pin_irq_out[3];
    endproperty
    a_pin_rise: assert property (p_pin_rise) else $error("missed rising event"); // RULE_05

    property p_no_fall;
        @(posedge clk_in) disable iff (rst_in)
        ($fell(sync2_q[3]) && !fall_en_q[3]) |=> !pin_irq_out[3];
    endproperty
    a_no_fall: assert property (p_no_fall) else $error("unselected edge fired"); // RULE_07

    property p_bank_irq;
        @(posedge clk_in) disable iff (rst_in)
        ##1 bank_irq_out[1] == $past(|ev[31:16]);
    endproperty
    a_bank_irq: assert property (p_bank_irq) else $error("bank irq mismatch"); // RULE_06

    property p_pin_dma;
        @(posedge clk_in) disable iff (rst_in)
        ##1 pin_dma_controller_event_out[3] ==
            $past((sync2_q[3] && !sync3_q[3] && rise_en_q[3])
                  || (!sync2_q[3] && sync3_q[3] && fall_en_q[3]));
    endproperty
    a_pin_dma: assert property (p_pin_dma) else $error("dma event differs"); // RULE_08

    property p_bank_dma;
        @(posedge clk_in) disable iff (rst_in)
        ##1 bank_dma_controller_event_out[6] == $past(|ev[103:96]);
    endproperty
    a_bank_dma: assert property (p_bank_dma) else $error("bank dma mismatch"); // RULE_09

    property p_set;
        @(posedge clk_in) disable iff (rst_in)
        s_set_write0 |=> out_q[15:0] == ($past(out_q[15:0]) | $past(pwdata_in[15:0]));
    endproperty
    a_set: assert property (p_set) else $error("set write wrong"); // RULE_10

    property p_out_read;
        @(posedge clk_in) disable iff (rst_in)
        (acc_first && !pwrite_in && acc_bank == 3'h0 && acc_idx == IDX_OUT && in_range)
        |=> prdata_out[15:0] == $past(out_q[15:0]);
    endproperty
    a_out_read: assert property (p_out_read) else $error("output read not drive"); // RULE_12

    // Clear, direction and status checks; the status one guards the set-wins choice.
    property p_clr;
        @(posedge clk_in) disable iff (rst_in)
        s_clr_write0 |=> out_q[15:0] == ($past(out_q[15:0]) & ~$past(pwdata_in[15:0]));
    endproperty
    a_clr: assert property (p_clr) else $error("clear write wrong"); // RULE_10

    property p_oe_drive;
        @(posedge clk_in) disable iff (rst_in)
        s_dir_write1 |=> pin_oe_n_out[31:16] == $past(pwdata_in[15:0]);
    endproperty
    a_oe_drive: assert property (p_oe_drive) else $error("pin enable misses write"); // RULE_01

    property p_stat_set;
        @(posedge clk_in) disable iff (rst_in)
        ev[3] |=> stat_q[3];
    endproperty
    a_stat_set: assert property (p_stat_set) else $error("event lost from status"); // RULE_05

    property p_irq_level;
        @(posedge clk_in) disable iff (rst_in)
        irq_out == |(stat_q & mask_q);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq level mismatch"); // RULE_05

endmodule : bgp_gpio

`default_nettype wire

// [rtl/bgp_pkg.sv]
// Constants for the banked general-purpose pin block with edge events.
package bgp_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int NUM_PINS   = 104;
    localparam int BANK_W     = 16;
    localparam int NUM_BANKS  = 7;
    localparam int FLAT_W     = NUM_BANKS * BANK_W;
    localparam int NUM_UNIQUE = 10;

    // Implemented pins; the upper half of the last bank is empty.
    localparam logic [FLAT_W-1:0] POP_MASK = {8'h00, {NUM_PINS{1'b1}}};

    // ------------------------------------------------------------------
    // Register map: byte address = bank * BANK_STRIDE + register offset
    // ------------------------------------------------------------------
    localparam logic [11:0] BANK_STRIDE = 12'h040;
    localparam logic [3:0]  IDX_DIR     = 4'h0;
    localparam logic [3:0]  IDX_OUT     = 4'h1;
    localparam logic [3:0]  IDX_SET     = 4'h2;
    localparam logic [3:0]  IDX_CLR     = 4'h3;
    localparam logic [3:0]  IDX_IN      = 4'h4;
    localparam logic [3:0]  IDX_RISE    = 4'h5;
    localparam logic [3:0]  IDX_FALL    = 4'h6;
    localparam logic [3:0]  IDX_STAT    = 4'h7;
    localparam logic [3:0]  IDX_MASK    = 4'h8;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [FLAT_W-1:0] DIR_RST  = {FLAT_W{1'b1}};
    localparam logic [FLAT_W-1:0] ZERO_RST = {FLAT_W{1'b0}};

endpackage : bgp_pkg

// [sim/bgp_pin_world.sv]
// Model of the external devices and board wiring on the general-purpose pins.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Pin wiring
// ----------------------------------------------------------------------
module bgp_pin_world
    import bgp_pkg::*;
(
    input  wire logic [NUM_PINS-1:0] ext_level_in,
    input  wire logic [NUM_PINS-1:0] ext_pull_low_in,
    input  wire logic [NUM_PINS-1:0] pin_out_in,
    input  wire logic [NUM_PINS-1:0] pin_oe_n_in,
    output wire logic [NUM_PINS-1:0] pin_level_out
);
    // A driven pin can still be pulled low from outside, as with wired logic.
    // An undriven pin shows only what the external device puts on it.
    assign pin_level_out = (~pin_oe_n_in & pin_out_in & ~ext_pull_low_in)
                         | (pin_oe_n_in & ext_level_in);
endmodule : bgp_pin_world

`default_nettype wire

// [sim/tb_top.sv]
// Self-checking testbench for the banked general-purpose pin block.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import bgp_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic                  clk_in, rst_in, psel, penable, pwrite;
    logic [11:0]           paddr;
    logic [31:0]           pwdata, prdata, rd;
    logic                  pready, pslverr, last_err, irq;
    logic [NUM_PINS-1:0]   ext_level, ext_pull, pin_lvl, pin_drv, oe_n;
    logic [NUM_UNIQUE-1:0] pin_irq, pin_dma;
    logic [NUM_BANKS-1:0]  bank_irq, bank_dma;
    int                    error_cnt, compares;
    int                    pi_c[10], pd_c[10], bi_c[7], bd_c[7];

    bgp_gpio u_dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .pin_in(pin_lvl), .pin_out(pin_drv),
        .pin_oe_n_out(oe_n), .pin_irq_out(pin_irq), .bank_irq_out(bank_irq),
        .pin_dma_controller_event_out(pin_dma), .bank_dma_controller_event_out(bank_dma),
        .irq_out(irq));

    bgp_pin_world u_world (.ext_level_in(ext_level), .ext_pull_low_in(ext_pull),
        .pin_out_in(pin_drv), .pin_oe_n_in(oe_n), .pin_level_out(pin_lvl));

    // ------------------------------------------------------------------
    // Clock, event counters and watchdog
    // ------------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    // Pulses are one cycle long, so counting high samples counts events.
    always @(posedge clk_in) begin
        for (int i = 0; i < NUM_UNIQUE; i++) begin
            if (pin_irq[i] === 1'b1) pi_c[i]++;
            if (pin_dma[i] === 1'b1) pd_c[i]++;
        end
        for (int i = 0; i < NUM_BANKS; i++) begin
            if (bank_irq[i] === 1'b1) bi_c[i]++;
            if (bank_dma[i] === 1'b1) bd_c[i]++;
        end
    end

    // The whole run needs a few hundred cycles; this margin catches a hung handshake.
    initial begin
        repeat (20000) @(posedge clk_in);
        error_cnt++;
        report_and_stop();
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    function automatic logic [11:0] ad(input int bank, input logic [3:0] idx);
        return 12'(bank) * BANK_STRIDE + {6'h00, idx, 2'b00};
    endfunction : ad

    // One APB transfer; the request is held until pready is seen high at an edge.
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        int n;
        n = 0;
        @(posedge clk_in);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= addr;
        pwdata <= data;
        @(posedge clk_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            error_cnt++;
            $display("ERROR apb pready expected 1 seen %b", pready);
        end
        rd       = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Changes one pin and counts the events it causes over the next eight cycles.
    task automatic edge_case(input int pin, input logic lvl, input int exp);
        int s_pi[10];
        int s_pd[10];
        int s_bi[7];
        int s_bd[7];
        s_pi = pi_c;
        s_pd = pd_c;
        s_bi = bi_c;
        s_bd = bd_c;
        @(posedge clk_in);
        ext_level[pin] <= lvl;
        repeat (8) @(posedge clk_in);
        check("bank irq count", 32'(exp), 32'(bi_c[pin/16] - s_bi[pin/16]));
        check("bank dma count", 32'(exp), 32'(bd_c[pin/16] - s_bd[pin/16]));
        if (pin < NUM_UNIQUE) begin
            check("pin irq count", 32'(exp), 32'(pi_c[pin] - s_pi[pin]));
            check("pin dma count", 32'(exp), 32'(pd_c[pin] - s_pd[pin]));
        end
    endtask : edge_case

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        check("oe_n idle", 32'h1, 32'(&oe_n));
        check("irq idle", 32'h0, {31'h0, irq});
        apb(1'b0, ad(0, IDX_DIR), 32'h0);
        check("dir reset", 32'h0000FFFF, rd);
        apb(1'b0, ad(0, IDX_OUT), 32'h0);
        check("out reset", 32'h0, rd);
        $display("test reset done");
    endtask : t_reset

    task automatic t_output();
        apb(1'b1, ad(1, IDX_DIR), 32'h0);
        apb(1'b1, ad(1, IDX_OUT), 32'h0000A5C3);
        @(posedge clk_in);
        check("pins driven", 32'h0000A5C3, {16'h0, pin_drv[31:16]});
        check("pins enabled", 32'h0, {16'h0, oe_n[31:16]});
        apb(1'b1, ad(1, IDX_SET), 32'h0000000C);
        apb(1'b1, ad(1, IDX_CLR), 32'h00000081);
        apb(1'b0, ad(1, IDX_OUT), 32'h0);
        check("set clear", 32'h0000A54E, rd);
        ext_pull[17] <= 1'b1;
        repeat (4) @(posedge clk_in);
        apb(1'b0, ad(1, IDX_IN), 32'h0);
        check("wired in", 32'h0000A54C, rd);
        apb(1'b0, ad(1, IDX_OUT), 32'h0);
        check("out not pin", 32'h0000A54E, rd);
        apb(1'b1, ad(0, IDX_OUT), 32'h00001234);
        apb(1'b1, ad(0, IDX_SET), 32'h00000003);
        apb(1'b1, ad(0, IDX_CLR), 32'h00000010);
        apb(1'b0, ad(0, IDX_OUT), 32'h0);
        check("bank0 set clear", 32'h00001227, rd);
        $display("test output done");
    endtask : t_output

    task automatic t_input();
        ext_level[63:48]  <= 16'h5A3C;
        ext_level[103:96] <= 8'hA5;
        repeat (4) @(posedge clk_in);
        apb(1'b0, ad(3, IDX_IN), 32'h0);
        check("bank3 in", 32'h00005A3C, rd);
        apb(1'b0, ad(6, IDX_IN), 32'h0);
        check("bank6 in", 32'h000000A5, rd);
        apb(1'b1, ad(6, IDX_DIR), 32'h0000FF00);
        apb(1'b0, ad(6, IDX_DIR), 32'h0);
        check("bank6 dir", 32'h00000000, rd);
        apb(1'b0, 12'h1C0, 32'h0);
        check("unmapped err", 32'h1, {31'h0, last_err});
        check("unmapped data", 32'h0, rd);
        $display("test input done");
    endtask : t_input

    task automatic t_edges();
        apb(1'b1, ad(0, IDX_RISE), 32'h00000008);
        edge_case(3, 1'b1, 1);
        edge_case(3, 1'b0, 0);
        apb(1'b1, ad(0, IDX_RISE), 32'h0);
        apb(1'b1, ad(0, IDX_FALL), 32'h00000008);
        edge_case(3, 1'b1, 0);
        edge_case(3, 1'b0, 1);
        apb(1'b1, ad(0, IDX_RISE), 32'h00000008);
        edge_case(3, 1'b1, 1);
        edge_case(3, 1'b0, 1);
        apb(1'b1, ad(2, IDX_RISE), 32'h00000100);
        edge_case(40, 1'b1, 1);
        edge_case(40, 1'b0, 0);
        $display("test edges done");
    endtask : t_edges

    task automatic t_irq();
        apb(1'b1, ad(0, IDX_STAT), 32'h0000FFFF);
        apb(1'b1, ad(0, IDX_MASK), 32'h00000008);
        edge_case(3, 1'b1, 1);
        check("irq set", 32'h1, {31'h0, irq});
        apb(1'b0, ad(0, IDX_STAT), 32'h0);
        check("status", 32'h00000008, rd);
        apb(1'b1, ad(0, IDX_STAT), 32'h00000008);
        repeat (2) @(posedge clk_in);
        check("irq cleared", 32'h0, {31'h0, irq});
        apb(1'b1, ad(0, IDX_MASK), 32'h0);
        edge_case(3, 1'b0, 1);
        check("irq masked", 32'h0, {31'h0, irq});
        $display("test irq done");
    endtask : t_irq

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_in    = 1'b1;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 12'h000;
        pwdata    = 32'h0;
        ext_level = '0;
        ext_pull  = '0;
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_output();
        t_input();
        t_edges();
        t_irq();
        report_and_stop();
    end
endmodule : tb_top

`default_nettype wire
